// ### shared/mole_pkg.sv
package mole_pkg;

    // =====================================================================
    // widths
    localparam int WORD_W  = 8;
    localparam int ADDR_W  = 7;
    localparam int INSTR_W = 14;

    // =====================================================================
    // instruction field positions
    localparam int DIR_BIT     = 7;   // destination select
    localparam int OP6_HI      = 13;  // six-bit opcode field top
    localparam int OP6_LO      = 8;
    localparam int OP7_LO      = 7;   // seven-bit opcode field bottom
    localparam int OP4_LO      = 10;  // four-bit opcode field bottom
    localparam int NOP_LOW_HI  = 4;   // low bits that must be zero for no-op

    // =====================================================================
    // opcode encodings
    localparam logic [5:0] OPC_OR_WORKING_WITH_FILE = 6'h04;
    localparam logic [5:0] OPC_MOVE_FILE_TO_DEST    = 6'h08;
    localparam logic [6:0] OPC_STORE_WORKING        = 7'h01;
    localparam logic [6:0] OPC_NOP_HI               = 7'h00;
    localparam logic [4:0] OPC_NOP_LO               = 5'h00;
    localparam logic [3:0] OPC_LOAD_LITERAL         = 4'hC;

    // =====================================================================
    // reset values
    localparam logic [WORD_W-1:0] W_RESET   = 8'h00;
    localparam logic              Z_RESET   = 1'b0;
    localparam logic [WORD_W-1:0] ZERO_WORD = 8'h00;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } mole_file_wr_type;

    typedef struct packed {
        logic [WORD_W-1:0] w;
        logic              z;
        mole_file_wr_type  wr;
        logic              pc_adv;
    } mole_state_type;

endpackage

// ### src/mole_exec.sv
`timescale 1ns/1ns
// Contract
// - or-with-file ORs working and file, sets zero
// - or-with-file direction 0 to working, 1 file
// - move-file copies file value unchanged
// - move-file direction 0 working, 1 same file
// - move-file updates zero for both destinations
// - store-working writes file, flags unchanged
// - load-literal loads working, flags unchanged
module mole_exec
    import mole_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire logic                   clk_en,
    input  wire logic                   instr_valid,
    input  wire logic [INSTR_W-1:0]     instr,
    output logic      [ADDR_W-1:0]      file_rd_addr,
    input  wire logic [WORD_W-1:0]      file_rd_data,
    output mole_file_wr_type            file_wr,
    output logic      [WORD_W-1:0]      w_out,
    output logic                        z_out,
    output logic                        pc_advance
);

    // =====================================================================
    // decode
    logic                   is_or;
    logic                   is_move;
    logic                   is_store;
    logic                   is_lit;
    logic                   is_nop;
    logic                   dir;
    logic [WORD_W-1:0]      or_res;
    mole_state_type         st_q;
    mole_state_type         st_d;

    // opcode classes from instruction fields
    assign is_or    = instr[OP6_HI:OP6_LO] == OPC_OR_WORKING_WITH_FILE;
    assign is_move  = instr[OP6_HI:OP6_LO] == OPC_MOVE_FILE_TO_DEST;
    assign is_store = instr[OP6_HI:OP7_LO] == OPC_STORE_WORKING;
    assign is_lit   = instr[OP6_HI:OP4_LO] == OPC_LOAD_LITERAL;
    assign is_nop   = (instr[OP6_HI:OP7_LO] == OPC_NOP_HI) && (instr[NOP_LOW_HI:0] == OPC_NOP_LO);
    assign dir      = instr[DIR_BIT];

    // file read address straight from the instruction
    assign file_rd_addr = instr[ADDR_W-1:0];
    assign or_res       = st_q.w | file_rd_data;

    // =====================================================================
    // next state: every instruction finishes in the cycle it is taken
    always_comb begin
        st_d           = st_q;
        st_d.wr.en     = 1'b0;
        st_d.pc_adv    = 1'b0;
        if (instr_valid) begin
            st_d.pc_adv  = is_or | is_move | is_store | is_lit | is_nop;
            st_d.wr.addr = instr[ADDR_W-1:0];
            if (is_or) begin
                st_d.z = or_res == ZERO_WORD;
                if (dir) begin
                    st_d.wr.en   = 1'b1;
                    st_d.wr.data = or_res;
                end else begin
                    st_d.w = or_res;
                end
            end else if (is_move) begin
                st_d.z = file_rd_data == ZERO_WORD;
                if (dir) begin
                    st_d.wr.en   = 1'b1;
                    st_d.wr.data = file_rd_data;
                end else begin
                    st_d.w = file_rd_data;
                end
            end else if (is_store) begin
                st_d.wr.en   = 1'b1;
                st_d.wr.data = st_q.w;
            end else if (is_lit) begin
                st_d.w = instr[WORD_W-1:0];
            end
        end
    end

    // state register, frozen while clk_en is low
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q.w       <= W_RESET;
            st_q.z       <= Z_RESET;
            st_q.wr.en   <= 1'b0;
            st_q.wr.addr <= '0;
            st_q.wr.data <= ZERO_WORD;
            st_q.pc_adv  <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // outputs from flip-flops
    assign file_wr    = st_q.wr;
    assign w_out      = st_q.w;
    assign z_out      = st_q.z;
    assign pc_advance = st_q.pc_adv;

    // =====================================================================
    // assertions
    logic take;
    assign take = clk_en && instr_valid;

    // which instructions may touch each piece of state
    logic known;
    logic w_writer;
    logic z_writer;
    logic f_writer;
    assign known    = is_or | is_move | is_store | is_lit | is_nop;
    assign w_writer = ((is_or | is_move) & ~dir) | is_lit;
    assign z_writer = is_or | is_move;
    assign f_writer = ((is_or | is_move) & dir) | is_store;

    property p_or_to_w;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_or && !dir |=> w_out == $past(or_res) && !file_wr.en
            && z_out == ($past(or_res) == ZERO_WORD);
    endproperty
    a_or_to_w: assert property (p_or_to_w) else $error("or to working wrong");

    property p_or_to_f;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_or && dir |=> file_wr.en && file_wr.data == $past(or_res)
            && file_wr.addr == $past(instr[ADDR_W-1:0]) && w_out == $past(w_out);
    endproperty
    a_or_to_f: assert property (p_or_to_f) else $error("or to file wrong");

    property p_move_w;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_move && !dir |=> w_out == $past(file_rd_data) && !file_wr.en;
    endproperty
    a_move_w: assert property (p_move_w) else $error("move to working wrong");

    property p_move_f;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_move && dir |=> file_wr.en && file_wr.data == $past(file_rd_data)
            && file_wr.addr == $past(file_rd_addr) && w_out == $past(w_out);
    endproperty
    a_move_f: assert property (p_move_f) else $error("move to file wrong");

    property p_move_z;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_move |=> z_out == ($past(file_rd_data) == ZERO_WORD);
    endproperty
    a_move_z: assert property (p_move_z) else $error("move zero flag wrong");

    property p_store;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_store |=> file_wr.en && file_wr.data == $past(w_out) && $stable(z_out)
            && $stable(w_out);
    endproperty
    a_store: assert property (p_store) else $error("store working wrong");

    property p_lit;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_lit |=> w_out == $past(instr[WORD_W-1:0]) && $stable(z_out) && !file_wr.en;
    endproperty
    a_lit: assert property (p_lit) else $error("load literal wrong");

    property p_nop;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_nop |=> !file_wr.en && $stable(w_out) && $stable(z_out) && pc_advance;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");

    property p_one_cycle;
        @(posedge core_clk) disable iff (!rst_b)
        take && (is_or || is_move || is_store || is_lit) |=> pc_advance;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("advance missing");

    property p_no_spurious;
        @(posedge core_clk) disable iff (!rst_b)
        clk_en && !instr_valid |=> !pc_advance && !file_wr.en;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("action without instruction");

    // =====================================================================
    // state guards: working and zero move, and write enable and advance are high, only when an instruction that owns them is taken
    property p_store_addr;
        @(posedge core_clk) disable iff (!rst_b)
        take && is_store |=> file_wr.addr == $past(instr[ADDR_W-1:0]) && pc_advance;
    endproperty
    a_store_addr: assert property (p_store_addr) else $error("store address wrong");

    property p_refuse;
        @(posedge core_clk) disable iff (!rst_b)
        take && !known |=> !pc_advance && !file_wr.en && $stable(w_out) && $stable(z_out);
    endproperty
    a_refuse: assert property (p_refuse) else $error("unknown word had an effect");

    property p_hold;
        @(posedge core_clk) disable iff (!rst_b)
        !clk_en |=> $stable(w_out) && $stable(z_out) && $stable(file_wr) && $stable(pc_advance);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while frozen");

    property p_w_only;
        @(posedge core_clk) disable iff (!rst_b)
        !(take && w_writer) |=> $stable(w_out);
    endproperty
    a_w_only: assert property (p_w_only) else $error("working changed without owner");

    property p_z_only;
        @(posedge core_clk) disable iff (!rst_b)
        !(take && z_writer) |=> $stable(z_out);
    endproperty
    a_z_only: assert property (p_z_only) else $error("zero flag changed without owner");

    property p_wr_only;
        @(posedge core_clk) disable iff (!rst_b)
        clk_en && !(take && f_writer) |=> !file_wr.en;
    endproperty
    a_wr_only: assert property (p_wr_only) else $error("file write without owner");

    property p_pc_only;
        @(posedge core_clk) disable iff (!rst_b)
        clk_en && !(take && known) |=> !pc_advance;
    endproperty
    a_pc_only: assert property (p_pc_only) else $error("advance without instruction");

endmodule

// ### bench/mole_file_model.sv
`timescale 1ns/1ns
// =====================================================================
// file register array on the far side of the exec slice
module mole_file_model
    import mole_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WORD_W-1:0] rd_data,
    input  wire mole_file_wr_type  wr
);
    logic [WORD_W-1:0] mem [128];
    // seed cells with a known pattern
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i + 8'h31);
        end
    end
    // same-cycle read of the addressed cell
    assign rd_data = mem[rd_addr];
    // write pulse lands on an enabled edge
    always @(posedge core_clk) begin
        if (clk_en && wr.en) begin
            mem[wr.addr] <= wr.data;
        end
    end
endmodule

// ### bench/mole_exec_tb.sv
`timescale 1ns/1ns
module mole_exec_tb
    import mole_pkg::*;
;
    logic                core_clk, rst_b, clk_en, instr_valid, z_out, pc_advance;
    logic [INSTR_W-1:0]  instr;
    logic [ADDR_W-1:0]   rd_addr;
    logic [WORD_W-1:0]   rd_data, w_out;
    mole_file_wr_type    file_wr;
    int                  n_fail, checked, cycles;
    mole_exec uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .instr_valid(instr_valid),
        .instr(instr), .file_rd_addr(rd_addr), .file_rd_data(rd_data), .file_wr(file_wr),
        .w_out(w_out), .z_out(z_out), .pc_advance(pc_advance));
    mole_file_model far (.core_clk(core_clk), .clk_en(clk_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr(file_wr));
    // =====================================================================
    // compare helpers
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk1(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask
    // one instruction for one enabled cycle, then look at the result
    task automatic exec(input logic [INSTR_W-1:0] word);
        @(posedge core_clk);
        instr <= word;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
        chk1("pc_advance", 1'b1, pc_advance);
    endtask
    task automatic chk_wr(input logic [6:0] a, input logic [7:0] d);
        chk1("wr en", 1'b1, file_wr.en);
        chk8("wr addr", {1'b0, a}, {1'b0, file_wr.addr});
        chk8("wr data", d, file_wr.data);
    endtask
    // =====================================================================
    // scenarios
    task automatic t_lit_store();
        exec(14'h3000);
        exec(14'h305A);
        chk8("w literal", 8'h5A, w_out);
        chk1("z literal", 1'b0, z_out);
        exec(14'h00FF);
        chk_wr(7'h7F, 8'h5A);
        exec(14'h3000);
        exec(14'h0080);
        chk_wr(7'h00, 8'h00);
        chk1("z store", 1'b0, z_out);
        $display("test literal and store done");
    endtask
    task automatic t_move();
        exec(14'h0880);
        chk_wr(7'h00, 8'h00);
        chk1("z move back", 1'b1, z_out);
        exec(14'h087F);
        chk8("w move", 8'h5A, w_out);
        chk1("z move w", 1'b0, z_out);
        exec(14'h0800);
        chk1("z move zero", 1'b1, z_out);
        $display("test move done");
    endtask
    task automatic t_or();
        exec(14'h3081);
        chk1("z literal kept", 1'b1, z_out);
        exec(14'h04FF);
        chk_wr(7'h7F, 8'hDB);
        chk8("w after or back", 8'h81, w_out);
        exec(14'h047F);
        chk8("w or", 8'hDB, w_out);
        chk1("z or", 1'b0, z_out);
        exec(14'h3000);
        exec(14'h0400);
        chk1("z or zero", 1'b1, z_out);
        exec(14'h0085);
        chk1("z store kept", 1'b1, z_out);
        $display("test or done");
    endtask
    task automatic t_nop();
        exec(14'h0000);
        chk1("nop wr en", 1'b0, file_wr.en);
        chk8("nop w", 8'h00, w_out);
        chk1("nop z", 1'b1, z_out);
        chk8("cell 127", 8'hDB, far.mem[127]);
        $display("test nop done");
    endtask
    // frozen cycle and an unknown word must leave everything as it was
    task automatic t_refuse();
        @(posedge core_clk);
        clk_en <= 1'b0;
        instr <= 14'h3077;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        clk_en <= 1'b1;
        instr <= 14'h3400;
        #1;
        chk8("w frozen", 8'h00, w_out);
        chk1("pc frozen", 1'b0, pc_advance);
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
        chk8("w unknown", 8'h00, w_out);
        chk1("z unknown", 1'b1, z_out);
        chk1("pc unknown", 1'b0, pc_advance);
        chk1("wr unknown", 1'b0, file_wr.en);
        $display("test refuse done");
    endtask
    task automatic final_report();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // =====================================================================
    // clock, watchdog and main sequence
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 500) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        t_lit_store();
        t_move();
        t_or();
        t_nop();
        t_refuse();
        final_report();
    end
endmodule
